// ### logic/general_digital_io_port.sv
// General digital I/O port with AXI4-Lite register access
`timescale 1ns/1ns
module general_digital_io_port
    import gpio_port_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [DATA_W/8-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Alternate function overrides, per pin
    input wire logic [PIN_COUNT-1:0] altEnable,
    input wire logic [PIN_COUNT-1:0] altOutEnable,
    input wire logic [PIN_COUNT-1:0] altOutValue,
    // Pins
    input wire logic [PIN_COUNT-1:0] pinIn,
    output logic [PIN_COUNT-1:0] pinOut,
    output logic [PIN_COUNT-1:0] pinOe,
    output logic [PIN_COUNT-1:0] pullupEn
);
    logic [PIN_COUNT-1:0] pinDriveValue_q;
    logic [PIN_COUNT-1:0] direction_q;
    logic globalPullupDisable_q;
    logic [PIN_COUNT-1:0] inputSample;

    logic [ADDR_W-1:0] wrAddr_q;
    logic [DATA_W-1:0] wrData_q;
    logic [DATA_W/8-1:0] wrStrb_q;
    logic wrGo;
    logic wrLane;
    logic [PIN_COUNT-1:0] wrBits;
    logic wrMapped;
    logic rdMapped;
    logic [DATA_W-1:0] rdWord;

    logic [PIN_COUNT-1:0] pinOut_d;
    logic [PIN_COUNT-1:0] pinOe_d;
    logic [PIN_COUNT-1:0] pullupEn_d;

    // Write executes once both address and data are held and no response is pending
    assign wrGo = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wrLane = wrStrb_q[DATA_LANE];
    assign wrBits = wrData_q[PIN_COUNT-1:0];

    // Address decode for writes
    always_comb begin
        unique case (wrAddr_q)
            PIN_DRIVE_VALUE_REG_ADDR,
            DIRECTION_REG_ADDR,
            INPUT_SAMPLE_REG_ADDR,
            MCU_CONTROL_REG_ADDR,
            DRIVE_SET_REG_ADDR,
            DRIVE_CLEAR_REG_ADDR,
            DIRECTION_SET_REG_ADDR,
            DIRECTION_CLEAR_REG_ADDR: wrMapped = 1'b1;
            default: wrMapped = 1'b0;
        endcase
    end

    // Write address channel: held until the response is taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            wrAddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            wrAddr_q <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    // Write data channel, independent of the address channel
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_wready <= 1'b1;
            wrData_q <= '0;
            wrStrb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wrData_q <= s_axi_wdata;
            wrStrb_q <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Write response, one cycle after both halves are held
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wrGo) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Drive value register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinDriveValue_q <= DRIVE_RESET;
        end else if (wrGo && wrLane) begin
            unique case (wrAddr_q)
                PIN_DRIVE_VALUE_REG_ADDR: begin
                    pinDriveValue_q <= wrBits;
                end
                // Ones toggle, zeros leave bits alone, direction ignored
                INPUT_SAMPLE_REG_ADDR: begin
                    pinDriveValue_q <= pinDriveValue_q ^ wrBits;
                end
                // Only addressed bits change
                DRIVE_SET_REG_ADDR: begin
                    pinDriveValue_q <= pinDriveValue_q | wrBits;
                end
                DRIVE_CLEAR_REG_ADDR: begin
                    pinDriveValue_q <= pinDriveValue_q & ~wrBits;
                end
                default: begin
                    pinDriveValue_q <= pinDriveValue_q;
                end
            endcase
        end
    end

    // Direction register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            direction_q <= DIRECTION_RESET;
        end else if (wrGo && wrLane) begin
            unique case (wrAddr_q)
                DIRECTION_REG_ADDR: begin
                    direction_q <= wrBits;
                end
                // Only addressed bits change
                DIRECTION_SET_REG_ADDR: begin
                    direction_q <= direction_q | wrBits;
                end
                DIRECTION_CLEAR_REG_ADDR: begin
                    direction_q <= direction_q & ~wrBits;
                end
                default: begin
                    direction_q <= direction_q;
                end
            endcase
        end
    end

    // Global pull-up disable in the control register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            globalPullupDisable_q <= PULLUP_DISABLE_RESET;
        end else if (wrGo && wrLane && wrAddr_q == MCU_CONTROL_REG_ADDR) begin
            globalPullupDisable_q <= wrData_q[PULLUP_DISABLE_BIT];
        end
    end

    // Pin level sampled every cycle, whatever the direction
    gpio_pin_sync u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pinLevel(pinIn),
        .sampleQ(inputSample)
    );

    // Read decode; sample location reads the synchroniser, while writes there toggle the drive bits
    always_comb begin
        rdWord = READ_DATA_RESET;
        rdMapped = 1'b1;
        unique case (s_axi_araddr)
            PIN_DRIVE_VALUE_REG_ADDR: rdWord[PIN_COUNT-1:0] = pinDriveValue_q;
            DIRECTION_REG_ADDR: rdWord[PIN_COUNT-1:0] = direction_q;
            INPUT_SAMPLE_REG_ADDR: rdWord[PIN_COUNT-1:0] = inputSample;
            MCU_CONTROL_REG_ADDR: rdWord[PULLUP_DISABLE_BIT] = globalPullupDisable_q;
            // Set and clear locations are write-only; they read as zero
            DRIVE_SET_REG_ADDR,
            DRIVE_CLEAR_REG_ADDR,
            DIRECTION_SET_REG_ADDR,
            DIRECTION_CLEAR_REG_ADDR: rdMapped = 1'b1;
            default: rdMapped = 1'b0;
        endcase
    end

    // Read channel: data one cycle after the address is taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= READ_DATA_RESET;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdWord;
            s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // Per-pin control; an override on one pin leaves the others as set
    genvar pinIdx;
    generate
        for (pinIdx = 0; pinIdx < PIN_COUNT; pinIdx++) begin : g_pin
            always_comb begin
                if (altEnable[pinIdx]) begin
                    pinOe_d[pinIdx] = altOutEnable[pinIdx];
                    pinOut_d[pinIdx] = altOutValue[pinIdx];
                    pullupEn_d[pinIdx] = 1'b0;
                end else begin
                    // One drives, zero listens
                    pinOe_d[pinIdx] = direction_q[pinIdx];
                    // Output level follows the drive bit while the pin drives, low otherwise
                    pinOut_d[pinIdx] = direction_q[pinIdx] & pinDriveValue_q[pinIdx];
                    // Pull-up only for input, drive one, no global disable
                    pullupEn_d[pinIdx] = !direction_q[pinIdx] && pinDriveValue_q[pinIdx]
                        && !globalPullupDisable_q;
                end
            end
        end
    endgenerate

    // Asynchronous clear tri-states the pins with no clock running
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinOe <= '0;
            pinOut <= '0;
            pullupEn <= '0;
        end else begin
            pinOe <= pinOe_d;
            pinOut <= pinOut_d;
            pullupEn <= pullupEn_d;
        end
    end
endmodule

// ### logic/gpio_pin_sync.sv
// Pin input synchroniser: clock-high latch followed by a rising-edge register
`timescale 1ns/1ns
module gpio_pin_sync
    import gpio_port_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pin levels and sampled result
    input wire logic [PIN_COUNT-1:0] pinLevel,
    output logic [PIN_COUNT-1:0] sampleQ
);
    logic [PIN_COUNT-1:0] syncLatch;

    // Transparent while clk is high, holds from the falling edge
    always_latch begin
        if (!rst_n) begin
            syncLatch <= SAMPLE_RESET;
        end else if (clk) begin
            syncLatch <= pinLevel;
        end
    end

    // Latched level lands on the next rising edge; only reader of the latch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sampleQ <= SAMPLE_RESET;
        end else begin
            sampleQ <= syncLatch;
        end
    end
endmodule

// ### logic/gpio_port_pkg.sv
// Constants shared by the general digital I/O port
package gpio_port_pkg;
    localparam int PIN_COUNT = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] PIN_DRIVE_VALUE_REG_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] DIRECTION_REG_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] INPUT_SAMPLE_REG_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] MCU_CONTROL_REG_ADDR = 8'h0C;
    localparam logic [ADDR_W-1:0] DRIVE_SET_REG_ADDR = 8'h10;
    localparam logic [ADDR_W-1:0] DRIVE_CLEAR_REG_ADDR = 8'h14;
    localparam logic [ADDR_W-1:0] DIRECTION_SET_REG_ADDR = 8'h18;
    localparam logic [ADDR_W-1:0] DIRECTION_CLEAR_REG_ADDR = 8'h1C;

    // Field positions
    localparam int PULLUP_DISABLE_BIT = 0;
    localparam int DATA_LANE = 0;

    // Reset values
    localparam logic [PIN_COUNT-1:0] DRIVE_RESET = 8'h00;
    localparam logic [PIN_COUNT-1:0] DIRECTION_RESET = 8'h00;
    localparam logic [PIN_COUNT-1:0] SAMPLE_RESET = 8'h00;
    localparam logic PULLUP_DISABLE_RESET = 1'b0;
    localparam logic [DATA_W-1:0] READ_DATA_RESET = 32'h0000_0000;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### verif/gpio_port_props.sv
// Port-level checks for the general digital I/O port
`timescale 1ns/1ns
module gpio_port_props
    import gpio_port_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic [PIN_COUNT-1:0] altEnable,
    input wire logic [PIN_COUNT-1:0] pinIn,
    input wire logic [PIN_COUNT-1:0] pinOut,
    input wire logic [PIN_COUNT-1:0] pinOe,
    input wire logic [PIN_COUNT-1:0] pullupEn
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_wTake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rTake;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // Reset check needs no clock-edge history, so it stays live in reset
    property p_rstTri;
        disable iff (1'b0) !rst_n |-> pinOe == 8'h00 && pullupEn == 8'h00 && pinOut == 8'h00;
    endproperty
    property p_outLow;
        altEnable == 8'h00 && $past(altEnable) == 8'h00 |-> (pinOut & ~pinOe) == 8'h00;
    endproperty
    property p_pullOut;
        (pullupEn & pinOe) == 8'h00;
    endproperty
    property p_bAns;
        s_wTake |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    property p_rAns;
        s_rTake |=> s_axi_rvalid;
    endproperty
    property p_rHold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
    endproperty
    property p_unmapped;
        s_rTake ##0 s_axi_araddr == 8'h20 |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    // Pins here move only on rising edges: latch at the fall, register at the rise, read one later
    property p_syncLag;
        s_rTake ##0 s_axi_araddr == INPUT_SAMPLE_REG_ADDR |=> s_axi_rdata[PIN_COUNT-1:0] == $past(pinIn, 2);
    endproperty
    property p_sample;
        $stable(pinIn) [*3] ##0 s_rTake ##0 s_axi_araddr == INPUT_SAMPLE_REG_ADDR
            |=> s_axi_rdata[7:0] == $past(pinIn);
    endproperty

    a_rstTri: assert property (p_rstTri) else $error("pins not released in reset");
    a_outLow: assert property (p_outLow) else $error("undriven pin shows high");
    a_pullOut: assert property (p_pullOut) else $error("pull-up on driven pin");
    a_bAns: assert property (p_bAns) else $error("write response timing wrong");
    a_rAns: assert property (p_rAns) else $error("read answer missing");
    a_rHold: assert property (p_rHold) else $error("read answer not held");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    a_sample: assert property (p_sample) else $error("sample read differs from pin");
    a_syncLag: assert property (p_syncLag) else $error("sample not two clocks behind pin");
endmodule

bind general_digital_io_port gpio_port_props u_props (
    .clk(clk),
    .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .altEnable(altEnable),
    .pinIn(pinIn),
    .pinOut(pinOut),
    .pinOe(pinOe),
    .pullupEn(pullupEn)
);

// ### verif/pin_partner.sv
// Board-side pin model: external drivers, pull-ups and floating lines
`timescale 1ns/1ns
module pin_partner
    import gpio_port_pkg::*;
(
    // Clock
    input wire logic clk,
    // Device side
    input wire logic [PIN_COUNT-1:0] pinOut,
    input wire logic [PIN_COUNT-1:0] pinOe,
    input wire logic [PIN_COUNT-1:0] pullupEn,
    // Board drivers
    input wire logic [PIN_COUNT-1:0] extEn,
    input wire logic [PIN_COUNT-1:0] extVal,
    output logic [PIN_COUNT-1:0] pinLevel
);
    logic [PIN_COUNT-1:0] floatQ = 8'h55;
    // Open lines wander so an unpulled input never reads steady
    always @(posedge clk) begin
        floatQ <= ~floatQ;
    end
    assign pinLevel = (pinOe & pinOut) | (~pinOe & extEn & extVal) | (~pinOe & ~extEn & (pullupEn | floatQ));
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the general digital I/O port
`timescale 1ns/1ns
module tb_top
    import gpio_port_pkg::*;
;
    logic clk = 1'h0;
    logic rstN = 1'h0;
    logic awValid = 1'h0, wValid = 1'h0, bReady = 1'h0, arValid = 1'h0, rReady = 1'h0;
    logic [7:0] awAddr = 8'h0, arAddr = 8'h0, altEn = 8'h0, altOe = 8'h0, altVal = 8'h0;
    logic [7:0] extEn = 8'h0, extVal = 8'h0;
    logic [31:0] wData = 32'h0;
    logic awReady, wReady, bValid, arReady, rValid;
    logic [1:0] bResp, rResp;
    logic [31:0] rData;
    logic [7:0] pinLevel, pinOut, pinOe, pullEn;
    int err_count = 0;
    int tests_run = 0;

    always #5 clk = ~clk;

    general_digital_io_port u_dut (.clk(clk), .rst_n(rstN),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .altEnable(altEn), .altOutEnable(altOe), .altOutValue(altVal),
        .pinIn(pinLevel), .pinOut(pinOut), .pinOe(pinOe), .pullupEn(pullEn));
    pin_partner u_pins (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pullupEn(pullEn),
        .extEn(extEn), .extVal(extVal), .pinLevel(pinLevel));

    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        bit aw;
        bit w;
        aw = 1;
        w = 1;
        @(posedge clk);
        awAddr <= a;
        wData <= d;
        awValid <= 1'h1;
        wValid <= 1'h1;
        bReady <= 1'h1;
        for (int n = 0; n < 40; n++) begin
            @(posedge clk);
            if (aw && awReady) begin
                aw = 0;
                awValid <= 1'h0;
            end
            if (w && wReady) begin
                w = 0;
                wValid <= 1'h0;
            end
            if (bValid) begin
                bReady <= 1'h0;
                chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, bResp});
                return;
            end
        end
        err_count++;
        close_out();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
        @(posedge clk);
        arAddr <= a;
        arValid <= 1'h1;
        rReady <= 1'h1;
        for (int n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arValid && arReady) begin
                arValid <= 1'h0;
            end
            if (rValid) begin
                rReady <= 1'h0;
                chk($sformatf("rdata %h", a), e, rData);
                chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rResp});
                return;
            end
        end
        err_count++;
        close_out();
    endtask

    task automatic pins(input logic [7:0] oe, input logic [7:0] out, input logic [7:0] pu);
        @(negedge clk);
        chk("pinOe", oe, pinOe);
        chk("pinOut", out, pinOut);
        chk("pullupEn", pu, pullEn);
    endtask

    task automatic t_out;
        wr(PIN_DRIVE_VALUE_REG_ADDR, 32'hA5);
        wr(DIRECTION_REG_ADDR, 32'hFF);
        pins(8'hFF, 8'hA5, 8'h00);
        // Let the pins settle so the steady-pin sample check gets a chance to fire
        repeat (2) @(posedge clk);
        rd(INPUT_SAMPLE_REG_ADDR, 32'hA5);
        $display("test outputs done");
    endtask

    task automatic t_toggle;
        wr(INPUT_SAMPLE_REG_ADDR, 32'h0F);
        rd(PIN_DRIVE_VALUE_REG_ADDR, 32'hAA);
        wr(INPUT_SAMPLE_REG_ADDR, 32'h0);
        rd(PIN_DRIVE_VALUE_REG_ADDR, 32'hAA);
        pins(8'hFF, 8'hAA, 8'h00);
        $display("test toggle done");
    endtask

    task automatic t_pull;
        wr(DIRECTION_REG_ADDR, 32'h0);
        extEn <= 8'hF0;
        extVal <= 8'h50;
        wr(PIN_DRIVE_VALUE_REG_ADDR, 32'h0F);
        pins(8'h00, 8'h00, 8'h0F);
        rd(INPUT_SAMPLE_REG_ADDR, 32'h5F);
        wr(MCU_CONTROL_REG_ADDR, 32'h1);
        pins(8'h00, 8'h00, 8'h00);
        rd(MCU_CONTROL_REG_ADDR, 32'h1);
        wr(MCU_CONTROL_REG_ADDR, 32'h0);
        $display("test pull-up done");
    endtask

    task automatic t_setclr;
        extEn <= 8'h00;
        wr(DRIVE_SET_REG_ADDR, 32'h80);
        wr(DRIVE_CLEAR_REG_ADDR, 32'h02);
        rd(PIN_DRIVE_VALUE_REG_ADDR, 32'h8D);
        wr(DIRECTION_SET_REG_ADDR, 32'h30);
        wr(DIRECTION_CLEAR_REG_ADDR, 32'h10);
        rd(DIRECTION_REG_ADDR, 32'h20);
        rd(DRIVE_SET_REG_ADDR, 32'h0);
        wr(8'h20, 32'hFF, RESP_SLVERR);
        rd(8'h20, 32'h0, RESP_SLVERR);
        rd(PIN_DRIVE_VALUE_REG_ADDR, 32'h8D);
        $display("test set-clear done");
    endtask

    task automatic t_alt;
        altEn <= 8'h01;
        altOe <= 8'h01;
        altVal <= 8'h01;
        @(posedge clk);
        pins(8'h21, 8'h01, 8'h8C);
        @(posedge clk);
        altEn <= 8'h00;
        $display("test alternate done");
    endtask

    task automatic t_rst2;
        @(posedge clk);
        rstN <= 1'h0;
        #1;
        chk("pinOe in reset", 8'h00, pinOe);
        chk("pullupEn in reset", 8'h00, pullEn);
        chk("pinOut in reset", 8'h00, pinOut);
        repeat (2) @(posedge clk);
        rstN <= 1'h1;
        rd(DIRECTION_REG_ADDR, 32'h0);
        rd(PIN_DRIVE_VALUE_REG_ADDR, 32'h0);
        $display("test reset done");
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rstN <= 1'h1;
        t_out();
        t_toggle();
        t_pull();
        t_setclr();
        t_alt();
        t_rst2();
        close_out();
    end
endmodule
